/* rtl/time_source_function_control.sv */
`timescale 1ns/1ps
`include "tsf_cfg.svh"
// Behaviour
// - Front output: pulse if select 0, error if 1
// - Multi-source changeover automatic or manual only
// - Time-base bit only used in special evaluation
// - Time-base 0: string local, derive UTC
// - Time-base 1: string UTC, derive local
// - Wrong time-base gives wrong times, unchecked
// - Evaluation 0: offsets from string status
// - Evaluation 1: internal offset and changeover
// - Simulation bit reports radio-synchronous status
// - Simulation ends after 4 hours or reset
// - Free-running mode keeps sync until reset
// - Latitude first, N/S, 00-89 deg, 00-59 min
// - Longitude after, E/W, 000-179, 00-59 min
// - Per-error major, minor or masked priority
// - Minor/major distinct only in dynamic mode
// - Error indicator while unmasked error active
// - Sixteen priorities in two groups of eight
// - One serial setting for all ports
// - Dynamic 980/20, 20/980, low; static low/high
// - Serial byte: string, data, parity, stop bits
// - Baud codes 100-111; default byte 10000110
module time_source_function_control #(
  parameter int MS_CYC  = (`CLK_HZ / 1000000) * `MS_US,
  parameter int SIM_SEC = `SIM_HOURS * 3600,
  parameter int CLK_HZ  = `CLK_HZ,
  parameter int MULTI   = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [31:0]           rdata,
  input  wire logic             pps_in,
  input  wire logic [15:0]      err_active,
  input  wire logic             source_sync,
  input  wire logic             primary_fail,
  input  wire logic             free_running_oscillator_mode,
  output logic                  front_out,
  output logic                  err_out,
  output logic                  radio_sync,
  output logic                  sim_display,
  output logic                  err_indicator,
  output logic                  use_secondary,
  output tsf_pkg::tbase_t       tbase,
  output tsf_pkg::ser_cfg_t     ser_cfg,
  output logic                  baud_tick
);

  // ****************************************
  // State and derived values
  // ****************************************
  tsf_pkg::state_t q, d;          // Registered state and next
  logic [15:0] major_v;            // Active errors rated major
  logic [15:0] minor_v;            // Active errors rated minor
  logic        any_major;          // At least one major error
  logic        any_minor;          // At least one minor error
  logic        any_err;            // Any unmasked error
  logic        ms_tick;            // One pulse per millisecond
  logic        sec_tick;           // One pulse per second
  logic [15:0] baud_div;           // Cycles per bit period
  logic [7:0]  func_w;             // Written settings byte
  logic        lat_good;           // Latitude entry in range
  logic        lon_good;           // Longitude entry in range

  // ****************************************
  // Priority decode, one slice per error
  // ****************************************
  // Code 10 major, 01 minor, 00 or 11 masked
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pri
      assign major_v[gi] = err_active[gi] &
                           (q.pri[2*gi +: 2] == 2'h2);
      assign minor_v[gi] = err_active[gi] &
                           (q.pri[2*gi +: 2] == 2'h1);
    end
  endgenerate

  assign any_major = |major_v;
  assign any_minor = |minor_v;
  assign any_err   = any_major | any_minor;

  // ****************************************
  // Timing enables
  // ****************************************
  assign ms_tick  = (q.ms_div == 16'(MS_CYC - 1));
  assign sec_tick = ms_tick & (q.ms_cnt == `FRAME_MS - 10'h001);

  // Bit period per code; unused codes give zero, no tick
  always_comb begin
    case (q.ser[2:0])
      3'h4:    baud_div = 16'(CLK_HZ / 2400);
      3'h5:    baud_div = 16'(CLK_HZ / 4800);
      3'h6:    baud_div = 16'(CLK_HZ / 9600);
      3'h7:    baud_div = 16'(CLK_HZ / 19200);
      default: baud_div = 16'h0000;
    endcase
  end

  // ****************************************
  // Position range checks
  // ****************************************
  // Degrees and minutes are plain binary fields, compared
  // against their decimal limits
  assign lat_good = (wdata[14:8] <= `LAT_DEG_MAX) &
                    (wdata[5:0]  <= `MIN_MAX);
  assign lon_good = (wdata[15:8] <= `LON_DEG_MAX) &
                    (wdata[5:0]  <= `MIN_MAX) & q.lat_ok;

  assign func_w = wdata[7:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.ser_tick = 1'b0;

    // Millisecond and frame counters
    if (ms_tick) begin
      d.ms_div = 16'h0000;
      d.ms_cnt = sec_tick ? 10'h000 : q.ms_cnt + 10'h001;
    end else begin
      d.ms_div = q.ms_div + 16'h0001;
    end

    // Baud divider shared by every serial port
    if (baud_div == 16'h0000) begin
      d.ser_div = 16'h0000;
    end else if (q.ser_div >= baud_div - 16'h0001) begin
      d.ser_div  = 16'h0000;
      d.ser_tick = 1'b1;
    end else begin
      d.ser_div = q.ser_div + 16'h0001;
    end

    // Simulation timer; oscillator mode holds sync
    // Expiry is a single cycle; a settings write in that same
    // cycle is applied below and so takes priority
    if (sec_tick && q.sim_sec != 14'h0000) begin
      d.sim_sec = q.sim_sec - 14'h0001;
      if (q.sim_sec == 14'h0001 && !free_running_oscillator_mode) begin
        d.func[`FB_SIM] = 1'b0;
      end
    end

    // Error output waveform over one second frame
    if (q.func[`FB_DYN]) begin
      if (any_major) begin
        d.err_out = 1'b0;
      end else if (any_minor) begin
        d.err_out = (d.ms_cnt < `DYN_SHRT_MS);
      end else begin
        d.err_out = (d.ms_cnt < `DYN_LONG_MS);
      end
    end else begin
      d.err_out = any_err;
    end

    // Connector carries the pulse or the error signal
    d.front = q.func[`FB_OUTSEL] ? d.err_out : pps_in;

    // Changeover: follow failure or software choice
    if (MULTI != 0) begin
      d.use_sec = q.func[`FB_MANUAL] ? q.sec_sel
                                     : primary_fail;
    end else begin
      d.use_sec = 1'b0;
    end

    // Simulated status overrides the real source
    d.sync = q.func[`FB_SIM] | source_sync;

    // Register writes; a settings write beats the timer
    if (wr) begin
      case (addr)
        `OFS_FUNC: begin
          d.func = func_w;
          if (func_w[`FB_SIM] && !q.func[`FB_SIM]) begin
            d.sim_sec = 14'(SIM_SEC);
          end
        end
        `OFS_SER:    d.ser = wdata[7:0];
        `OFS_PRI_LO: d.pri[15:0]  = wdata[15:0];
        `OFS_PRI_HI: d.pri[31:16] = wdata[15:0];
        `OFS_LAT: begin
          d.pos_rej = !lat_good;
          if (lat_good) begin
            d.lat    = wdata[15:0];
            d.lat_ok = 1'b1;
          end
        end
        `OFS_LON: begin
          d.pos_rej = !lon_good;
          if (lon_good) begin
            d.lon = wdata[16:0];
          end
        end
        `OFS_CTRL:   d.sec_sel = wdata[0];
        default: begin
          // Unmapped write is dropped; timer expiry still lands
        end
      endcase
    end

    // Read data stands only in the next cycle
    d.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `OFS_FUNC:   d.rdata = {24'h000000, q.func};
        `OFS_SER:    d.rdata = {24'h000000, q.ser};
        `OFS_PRI_LO: d.rdata = {16'h0000, q.pri[15:0]};
        `OFS_PRI_HI: d.rdata = {16'h0000, q.pri[31:16]};
        `OFS_LAT:    d.rdata = {16'h0000, q.lat};
        `OFS_LON:    d.rdata = {15'h0000, q.lon};
        `OFS_STAT:   d.rdata = {24'h000000, 1'b0, q.use_sec,
                                q.pos_rej, q.lat_ok, any_major,
                                any_err, q.func[`FB_SIM], q.sync};
        `OFS_CTRL:   d.rdata = {31'h00000000, q.sec_sel};
        default:     d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q         <= '0;
      q.func    <= `RST_FUNC;
      q.ser     <= `RST_SER;
      q.pri     <= {`RST_PRI, `RST_PRI};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata         = q.rdata;
  assign front_out     = q.front;
  assign err_out       = q.err_out;
  assign radio_sync    = q.sync;
  assign sim_display   = q.func[`FB_SIM];
  assign err_indicator = any_err;
  assign use_secondary = q.use_sec;
  assign baud_tick     = q.ser_tick;
  assign ser_cfg       = tsf_pkg::ser_cfg_t'(q.ser);

  // Time base counts only under special evaluation; a wrong
  // setting simply yields wrong times, nothing detects it
  assign tbase.use_internal_ofs = q.func[`FB_EVAL];
  assign tbase.string_is_utc    = q.func[`FB_EVAL] &
                                  q.func[`FB_TBASE];
  assign tbase.derive_utc       = q.func[`FB_EVAL] &
                                  !q.func[`FB_TBASE];
  assign tbase.derive_local     = q.func[`FB_EVAL] &
                                  q.func[`FB_TBASE];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Connector and error output
  front_sel_a: assert property (
    !q.func[`FB_OUTSEL] && !(wr && addr == `OFS_FUNC)
      |=> front_out == $past(pps_in))
    else $error("front output not the pulse");

  major_low_a: assert property (
    q.func[`FB_DYN] && any_major |=> !err_out)
    else $error("major error not steady low");

  // Away from the short high window and the frame wrap
  minor_low_a: assert property (
    q.func[`FB_DYN] && any_minor && !any_major &&
    q.ms_cnt > `DYN_SHRT_MS && q.ms_cnt < `FRAME_MS - 10'h002
      |=> !err_out)
    else $error("minor error not mostly low");

  none_high_a: assert property (
    q.func[`FB_DYN] && !any_err &&
    q.ms_cnt < `DYN_LONG_MS - 10'h002 |=> err_out)
    else $error("no-error waveform not high");

  static_err_a: assert property (
    !q.func[`FB_DYN] && !(wr && addr == `OFS_FUNC)
      |=> err_out == $past(any_err))
    else $error("static error level wrong");

  // Simulation timer and reported status
  sim_load_a: assert property (
    wr && addr == `OFS_FUNC && wdata[`FB_SIM] && !q.func[`FB_SIM]
      |=> q.sim_sec == 14'(SIM_SEC))
    else $error("simulation timer not restarted");

  sim_expire_a: assert property (
    sec_tick && q.sim_sec == 14'h0001 &&
    !free_running_oscillator_mode && !wr
      |=> !sim_display)
    else $error("simulation did not expire");

  osc_hold_a: assert property (
    free_running_oscillator_mode && sim_display && !wr
      |=> sim_display)
    else $error("oscillator mode lost sync");

  sim_sync_a: assert property (
    sim_display |=> radio_sync)
    else $error("simulation not reported sync");

  real_sync_a: assert property (
    !sim_display && !source_sync |=> !radio_sync)
    else $error("sync reported without cause");

  // Position entry
  lat_range_a: assert property (
    wr && addr == `OFS_LAT && wdata[14:8] > `LAT_DEG_MAX
      |=> q.lat == $past(q.lat))
    else $error("bad latitude accepted");

  lat_take_a: assert property (
    wr && addr == `OFS_LAT && lat_good
      |=> q.lat_ok && !q.pos_rej)
    else $error("good latitude refused");

  lon_order_a: assert property (
    wr && addr == `OFS_LON && !q.lat_ok
      |=> q.lon == $past(q.lon) && q.pos_rej)
    else $error("longitude before latitude");

  // Register port, time base and serial setting
  tbase_gate_a: assert property (
    !q.func[`FB_EVAL] |-> !tbase.string_is_utc &&
      !tbase.derive_utc && !tbase.derive_local)
    else $error("time base used in standard mode");

  baud_off_a: assert property (
    !q.ser[2] |=> !baud_tick)
    else $error("tick on unused baud code");

  read_func_a: assert property (
    rd && addr == `OFS_FUNC |=> rdata == {24'h000000,
      $past(q.func)} ##1 rdata == 32'h0000_0000 || $past(rd))
    else $error("settings read back wrong");

  rd_idle_a: assert property (
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  // Source changeover
  auto_sw_a: assert property (
    MULTI != 0 && !q.func[`FB_MANUAL] |=>
      use_secondary == $past(primary_fail))
    else $error("automatic changeover wrong");

  manual_sw_a: assert property (
    MULTI != 0 && q.func[`FB_MANUAL] |=>
      use_secondary == $past(q.sec_sel))
    else $error("manual changeover wrong");

  sim_start_c: cover property (
    wr && addr == `OFS_FUNC && wdata[0] ##1 sim_display);
  dyn_minor_c: cover property (
    q.func[`FB_DYN] && any_minor && !any_major ##1 err_out);
  pos_entry_c: cover property (
    wr && addr == `OFS_LAT && lat_good
      ##[1:8] wr && addr == `OFS_LON && lon_good);
  sim_end_c: cover property (
    sim_display ##1 !sim_display);
  manual_sel_c: cover property (
    q.func[`FB_MANUAL] && q.sec_sel ##1 use_secondary);

endmodule : time_source_function_control

/* include/tsf_cfg.svh */
`ifndef TSF_CFG_SVH
`define TSF_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_FUNC    8'h00
`define OFS_SER     8'h04
`define OFS_PRI_LO  8'h08
`define OFS_PRI_HI  8'h0C
`define OFS_LAT     8'h10
`define OFS_LON     8'h14
`define OFS_STAT    8'h18
`define OFS_CTRL    8'h1C

// ****************************************
// Function settings bit positions
// ****************************************
`define FB_SIM      0
`define FB_EVAL     1
`define FB_TBASE    2
`define FB_MANUAL   3
`define FB_OUTSEL   4
`define FB_DYN      5

// ****************************************
// Reset values
// ****************************************
`define RST_FUNC    8'h00
`define RST_SER     8'h86
`define RST_PRI     16'hAAAA

// ****************************************
// Ranges and timing
// ****************************************
`define LAT_DEG_MAX 7'h59
`define LON_DEG_MAX 8'hB3
`define MIN_MAX     6'h3B
`define CLK_HZ      40000000
`define MS_US       1000
`define SIM_HOURS   4
`define FRAME_MS    10'h3E8
`define DYN_LONG_MS 10'h3D4
`define DYN_SHRT_MS 10'h014

`endif

/* include/tsf_pkg.sv */
package tsf_pkg;

  // Serial setting shared by every serial port
  typedef struct packed {
    logic       string_out_en; // Master/slave string output on
    logic       seven_bits;    // 1: 7 data bits, 0: 8
    logic [1:0] parity;        // 00 none, 10 even, 11 odd
    logic       two_stop;      // 1: two stop bits
    logic [2:0] baud_code;     // 100..111: 2400..19200
  } ser_cfg_t;

  // Time string interpretation flags
  typedef struct packed {
    logic string_is_utc;      // Received time is UTC
    logic derive_utc;         // UTC computed from local
    logic derive_local;       // Local computed from UTC
    logic use_internal_ofs;   // Internal offset and changeover
  } tbase_t;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0]  func;
    logic [7:0]  ser;
    logic [31:0] pri;
    logic [15:0] lat;
    logic [16:0] lon;
    logic        lat_ok;
    logic        pos_rej;
    logic        sec_sel;
    logic        use_sec;
    logic [15:0] ms_div;
    logic [9:0]  ms_cnt;
    logic [13:0] sim_sec;
    logic [15:0] ser_div;
    logic        ser_tick;
    logic        err_out;
    logic        front;
    logic        sync;
    logic [31:0] rdata;
  } state_t;

endpackage : tsf_pkg

/* tb/tsf_partner.sv */
`timescale 1ns/1ps
// ****************************************
// Far side: time source and error sources
// ****************************************
module tsf_partner #(
  parameter int PPS_CYC = 40
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] err_req,
  input  wire logic        fail_req,
  output logic             pps_in,
  output logic [15:0]      err_active,
  output logic             source_sync,
  output logic             primary_fail
);
  int cnt_q; // Cycles since the last second pulse

  // Sources change just after the edge, as real equipment would
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q        <= 0;
      pps_in       <= 1'h0;
      err_active   <= 16'h0;
      primary_fail <= 1'h0;
    end else begin
      cnt_q        <= (cnt_q == PPS_CYC - 1) ? 0 : cnt_q + 1;
      pps_in       <= (cnt_q == PPS_CYC - 1);
      err_active   <= err_req;
      primary_fail <= fail_req;
    end
  end

  // Never locked, so only simulation can report sync
  assign source_sync = 1'h0;
endmodule : tsf_partner

/* tb/time_source_function_control_test.sv */
`timescale 1ns/1ps
`include "tsf_cfg.svh"
module time_source_function_control_test;
  // ****************************************
  // Signals
  // ****************************************
  logic              ref_clk = 1'h0;
  logic              resetn, wr, rd, fail_req, osc_mode;
  logic [7:0]        addr;
  logic [31:0]       wdata, rdata, v;
  logic [15:0]       err_req, err_active;
  logic              pps_in, source_sync, primary_fail, front_out;
  logic              err_out, radio_sync, sim_display, err_indicator;
  logic              use_secondary, baud_tick;
  tsf_pkg::tbase_t   tbase;
  tsf_pkg::ser_cfg_t ser_cfg;
  int                err_count, check_count, n;
  logic [3:0]        tb_exp [4] = '{4'h0, 4'h5, 4'h0, 4'hB};
  // Position table: address, data, expected reject flag
  logic [7:0]        pa [6] = '{8'h14, 8'h10, 8'h10, 8'h10, 8'h14, 8'h14};
  logic [31:0]       pd [6] = '{32'h1230, 32'h7F00, 32'h853C, 32'h4530,
                                32'h11759, 32'hB400};
  logic              pr [6] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  always #12.5 ref_clk = ~ref_clk;

  // Short counts keep the run brief: 4 cycles a ms, 3 s simulation
  time_source_function_control #(.MS_CYC(4), .SIM_SEC(3))
    u_time_source_function_control (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pps_in(pps_in),
    .err_active(err_active), .source_sync(source_sync),
    .primary_fail(primary_fail), .free_running_oscillator_mode(osc_mode),
    .front_out(front_out), .err_out(err_out), .radio_sync(radio_sync),
    .sim_display(sim_display), .err_indicator(err_indicator),
    .use_secondary(use_secondary), .tbase(tbase), .ser_cfg(ser_cfg),
    .baud_tick(baud_tick));

  tsf_partner u_tsf_partner (
    .ref_clk(ref_clk), .resetn(resetn), .err_req(err_req),
    .fail_req(fail_req), .pps_in(pps_in), .err_active(err_active),
    .source_sync(source_sync), .primary_fail(primary_fail));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr    <= 1'h0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
    rd   <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  function automatic logic pick(input int s);
    return (s == 0) ? pps_in : (s == 1) ? baud_tick : sim_display;
  endfunction : pick

  // Bounded wait; a used-up bound ends the run as a failure
  task automatic wait_for(input int s, input logic val, input int lim);
    #1;
    n = 0;
    while (pick(s) !== val) begin
      cyc(1);
      n++;
      if (n > lim) begin
        err_count++;
        finish_test();
      end
    end
  endtask : wait_for

  task automatic set_src(input logic [15:0] e, input logic f);
    @(posedge ref_clk);
    err_req  <= e;
    fail_req <= f;
    cyc(4);
  endtask : set_src

  // Over a whole 1000 ms frame the high time is phase independent
  task automatic high_count;
    n = 0;
    repeat (4000) begin
      cyc(1);
      if (err_out === 1'h1) n++;
    end
  endtask : high_count

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {resetn, wr, rd, fail_req, osc_mode} = 5'h0;
    addr    = 8'h0;
    wdata   = 32'h0;
    err_req = 16'h0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    rd_reg(`OFS_FUNC, v);
    check(v, 32'h0);
    rd_reg(`OFS_SER, v);
    check(v, 32'h86);
    rd_reg(`OFS_PRI_LO, v);
    check(v, 32'hAAAA);
    rd_reg(8'h20, v); // Unmapped place reads as zero
    check(v, 32'h0);
    wr_reg(8'h20, 32'hFF); // Unmapped write is dropped
    rd_reg(`OFS_FUNC, v);
    check(v, 32'h0);
    // Every baud code; slowest period bounds the wait
    for (int c = 0; c < 8; c++) begin
      wr_reg(`OFS_SER, 32'hB8 | c);
      cyc(2);
      check(ser_cfg, 32'hB8 | c);
      if (c < 4) begin
        repeat (2100) begin
          cyc(1);
          check(baud_tick, 32'h0);
        end
      end else begin
        wait_for(1, 1'h1, 17000);
      end
    end
    cyc(1);
    wait_for(1, 1'h1, 2100);
    check(n > 2080 && n < 2086, 32'h1);
    // Pulse on the connector while select is clear
    wr_reg(`OFS_FUNC, 32'h00);
    wait_for(0, 1'h1, 100);
    cyc(1);
    check(front_out, 32'h1);
    cyc(1);
    check(front_out, 32'h0);
    // Static error drives the switchover unit
    wr_reg(`OFS_FUNC, 32'h10);
    set_src(16'h1, 1'h0);
    check(err_out, 32'h1);
    check(front_out, 32'h1);
    check(err_indicator, 32'h1);
    set_src(16'h0, 1'h0);
    check(err_out, 32'h0);
    // Error 0 masked, error 1 minor
    wr_reg(`OFS_PRI_LO, 32'hAAA4);
    set_src(16'h1, 1'h0);
    check(err_out, 32'h0);
    check(err_indicator, 32'h0);
    set_src(16'h2, 1'h0);
    check(err_out, 32'h1);
    // Dynamic output: minor, major, none
    wr_reg(`OFS_FUNC, 32'h30);
    cyc(10);
    high_count();
    check(n, 32'h50);
    set_src(16'h4, 1'h0);
    high_count();
    check(n, 32'd0);
    set_src(16'h0, 1'h0);
    high_count();
    check(n, 32'hF50);
    // Upper group leaves lower group untouched
    wr_reg(`OFS_PRI_HI, 32'h5555);
    rd_reg(`OFS_PRI_HI, v);
    check(v, 32'h5555);
    rd_reg(`OFS_PRI_LO, v);
    check(v, 32'hAAA4);
    // Time base counts only in special evaluation
    for (int i = 0; i < 4; i++) begin
      wr_reg(`OFS_FUNC, i << 1);
      cyc(2);
      check(tbase, tb_exp[i]);
    end
    // Automatic then manual changeover
    wr_reg(`OFS_FUNC, 32'h00);
    set_src(16'h0, 1'h1);
    check(use_secondary, 32'h1);
    wr_reg(`OFS_FUNC, 32'h08);
    wr_reg(`OFS_CTRL, 32'h0);
    set_src(16'h0, 1'h1);
    check(use_secondary, 32'h0);
    wr_reg(`OFS_CTRL, 32'h1);
    cyc(3);
    check(use_secondary, 32'h1);
    set_src(16'h0, 1'h0);
    // Position entry ranges and order
    for (int i = 0; i < 6; i++) begin
      wr_reg(pa[i], pd[i]);
      rd_reg(`OFS_STAT, v);
      check(v[5], pr[i]);
    end
    rd_reg(`OFS_LAT, v);
    check(v, 32'h4530);
    // Simulation, restarted by a fresh set, then expiry
    wr_reg(`OFS_FUNC, 32'h01);
    cyc(1);
    check(sim_display, 32'h1);
    check(radio_sync, 32'h1);
    cyc(6000);
    wr_reg(`OFS_FUNC, 32'h00);
    wr_reg(`OFS_FUNC, 32'h01);
    wait_for(2, 1'h0, 12010);
    check(n > 7900, 32'h1);
    cyc(2);
    check(radio_sync, 32'h0);
    // Oscillator mode holds sync until reset
    @(posedge ref_clk);
    osc_mode <= 1'h1;
    wr_reg(`OFS_FUNC, 32'h01);
    cyc(12100);
    check(radio_sync, 32'h1);
    @(posedge ref_clk);
    resetn <= 1'h0;
    cyc(3);
    check(radio_sync, 32'h0);
    @(posedge ref_clk);
    resetn <= 1'h1;
    cyc(2);
    check(sim_display, 32'h0);
    finish_test();
  end
endmodule : time_source_function_control_test
